// *** rtl/led_slot_cfg_pkg.sv ***
package led_slot_cfg_pkg;

    // Host control port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [ADDR_W-1:0] SLOT_SEL_ADDR = 8'h14;
    localparam logic [ADDR_W-1:0] CURRENT_CFG_ADDR = 8'h23;

    // Reset values
    localparam logic [DATA_W-1:0] SLOT_SEL_RESET = 16'h0541;
    localparam logic [DATA_W-1:0] CURRENT_CFG_RESET = 16'h3000;

    // Field widths
    localparam int DET_W = 4;
    localparam int EM_W = 2;
    localparam int COARSE_W = 4;
    localparam int FINE_W = 5;
    localparam int RSVD_TOP_W = 4;

    // Field positions in the slot selection register
    localparam int RSVD_TOP_LSB = 12;
    localparam int SEC_DET_LSB = 8;
    localparam int FIRST_DET_LSB = 4;
    localparam int SEC_EM_LSB = 2;
    localparam int FIRST_EM_LSB = 0;

    // Field positions in the emitter one current register
    localparam int SCALE_BIT = 13;
    localparam int COARSE_LSB = 0;

    // Detector and emitter select codes
    localparam logic [DET_W-1:0] DET_PAIR_CODE = 4'h1;
    localparam logic [DET_W-1:0] DET_ALL_CODE = 4'h4;
    localparam logic [EM_W-1:0] EM_ONE_CODE = 2'h1;
    localparam logic [EM_W-1:0] EM_TWO_CODE = 2'h2;

    // Detector masks, bit 0 is channel 1
    localparam logic [DET_W-1:0] DET_PAIR_MASK = 4'hc;
    localparam logic [DET_W-1:0] DET_ALL_MASK = 4'hf;
    localparam logic [DET_W-1:0] DET_NONE_MASK = 4'h0;

    // Current arithmetic widths
    localparam int COARSE_VAL_W = 10;
    localparam int FINE_VAL_W = 11;
    localparam int SCALE_VAL_W = 4;
    localparam int NOMINAL_W = 8;
    localparam int PEAK_W = COARSE_VAL_W + FINE_VAL_W + SCALE_VAL_W;

    // Coarse target in half mA: 28 mA plus 15.5 mA per step
    localparam logic [COARSE_VAL_W-1:0] COARSE_BASE_HALF_MA = 10'h038;
    localparam logic [COARSE_VAL_W-1:0] COARSE_STEP_HALF_MA = 10'h01f;
    // Fine multiplier in thousandths: 0.71 plus 0.024 per step
    localparam logic [FINE_VAL_W-1:0] FINE_BASE_MILLI = 11'h2c6;
    localparam logic [FINE_VAL_W-1:0] FINE_STEP_MILLI = 11'h018;
    // Scale multiplier in tenths: 0.4, or 0.4 plus 0.6
    localparam logic [SCALE_VAL_W-1:0] SCALE_LOW_TENTHS = 4'h4;
    localparam logic [SCALE_VAL_W-1:0] SCALE_STEP_TENTHS = 4'h6;
    // Nominal listed current in mA: 25 mA plus 15 mA per step
    localparam logic [NOMINAL_W-1:0] NOMINAL_BASE_MA = 8'h19;
    localparam logic [NOMINAL_W-1:0] NOMINAL_STEP_MA = 8'h0f;

endpackage

// *** rtl/emitter_one_current_calc.sv ***
`timescale 1ns/1ps
module emitter_one_current_calc (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic scale_bit_i,
    input wire logic [led_slot_cfg_pkg::COARSE_W-1:0] coarse_code_i,
    input wire logic [led_slot_cfg_pkg::FINE_W-1:0] fine_code_i,
    output logic [led_slot_cfg_pkg::SCALE_VAL_W-1:0] scale_tenths_o,
    output logic [led_slot_cfg_pkg::COARSE_VAL_W-1:0] coarse_half_ma_o,
    output logic [led_slot_cfg_pkg::FINE_VAL_W-1:0] fine_milli_o,
    output logic [led_slot_cfg_pkg::NOMINAL_W-1:0] nominal_ma_o,
    output logic [led_slot_cfg_pkg::PEAK_W-1:0] peak_target_o
);
    import led_slot_cfg_pkg::*;

    typedef struct packed {
        logic [SCALE_VAL_W-1:0] scale;
        logic [COARSE_VAL_W-1:0] coarse;
        logic [FINE_VAL_W-1:0] fine;
        logic [NOMINAL_W-1:0] nominal;
        logic [PEAK_W-1:0] peak;
    } calc_state_s;

    calc_state_s state_reg;
    calc_state_s state_next;

    // Multipliers from the codes, peak from last cycle's multipliers
    always_comb begin
        state_next = state_reg;
        state_next.scale = SCALE_LOW_TENTHS + (scale_bit_i ? SCALE_STEP_TENTHS : 4'h0); // [R6]
        state_next.coarse = COARSE_BASE_HALF_MA
            + COARSE_STEP_HALF_MA * COARSE_VAL_W'(coarse_code_i); // [R7]
        state_next.fine = FINE_BASE_MILLI + FINE_STEP_MILLI * FINE_VAL_W'(fine_code_i); // [R8]
        state_next.nominal = NOMINAL_BASE_MA + NOMINAL_STEP_MA * NOMINAL_W'(coarse_code_i); // [R9]
        state_next.peak = PEAK_W'(state_reg.coarse) * PEAK_W'(state_reg.fine)
            * PEAK_W'(state_reg.scale); // [R8]
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign scale_tenths_o = state_reg.scale;
    assign coarse_half_ma_o = state_reg.coarse;
    assign fine_milli_o = state_reg.fine;
    assign nominal_ma_o = state_reg.nominal;
    assign peak_target_o = state_reg.peak;

endmodule

// *** rtl/led_slot_config_regs.sv ***
`timescale 1ns/1ps
// Functional notes
// [R1] Second slot detector code 0x1 connects channels 3,4; 0x4 connects all four.
// [R2] First slot detector code 0x1 connects channels 3,4; 0x4 connects all four.
// [R3] Second slot emitter code 0x1 pulses emitter one, 0x2 emitter two.
// [R4] First slot emitter code 0x1 pulses emitter one, 0x2 emitter two.
// [R5] Software writes zero into slot selection bits 15 to 12.
// [R6] Scale bit gives multiplier 0.4 plus 0.6 times the bit.
// [R7] Coarse target is 28 mA plus 15.5 mA per code step.
// [R8] Peak equals coarse times fine times scale; fine is 0.71 plus 0.024 per step.
// [R9] Nominal coarse listing is 25 mA plus 15 mA per step.
// [R10] Slot selections latched at slot start, applied only during that slot.
module led_slot_config_regs (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [led_slot_cfg_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [led_slot_cfg_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [led_slot_cfg_pkg::FINE_W-1:0] emitter_one_fine_code_i,
    input wire logic first_slot_start_i,
    input wire logic second_slot_start_i,
    input wire logic first_slot_active_i,
    input wire logic second_slot_active_i,
    output logic [led_slot_cfg_pkg::DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic reg_addr_err_o,
    output logic [led_slot_cfg_pkg::DET_W-1:0] detector_connect_o,
    output logic emitter_one_pulse_o,
    output logic emitter_two_pulse_o,
    output logic emitter_one_scale_o,
    output logic [led_slot_cfg_pkg::COARSE_W-1:0] emitter_one_coarse_code_o,
    output logic [led_slot_cfg_pkg::SCALE_VAL_W-1:0] emitter_one_scale_tenths_o,
    output logic [led_slot_cfg_pkg::COARSE_VAL_W-1:0] emitter_one_coarse_half_ma_o,
    output logic [led_slot_cfg_pkg::FINE_VAL_W-1:0] emitter_one_fine_milli_o,
    output logic [led_slot_cfg_pkg::NOMINAL_W-1:0] emitter_one_nominal_ma_o,
    output logic [led_slot_cfg_pkg::PEAK_W-1:0] emitter_one_peak_target_o
);
    import led_slot_cfg_pkg::*;

    typedef enum logic [1:0] {
        SLOT_IDLE = 2'b00,
        SLOT_FIRST = 2'b01,
        SLOT_SECOND = 2'b10
    } slot_phase_e;

    typedef struct packed {
        logic [DATA_W-1:0] slot_sel;
        logic [DATA_W-1:0] current_cfg;
        logic [DET_W-1:0] first_det;
        logic [EM_W-1:0] first_em;
        logic [DET_W-1:0] second_det;
        logic [EM_W-1:0] second_em;
        slot_phase_e phase;
        logic [DET_W-1:0] det_connect;
        logic em_one;
        logic em_two;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic addr_err;
    } bank_state_s;

    // Registered state and its next value
    bank_state_s state_reg;
    bank_state_s state_next;

    // Pending slot selection, its field codes and the live slot's selection
    logic [DATA_W-1:0] slot_sel_new;
    logic [DET_W-1:0] first_det_code;
    logic [EM_W-1:0] first_em_code;
    logic [DET_W-1:0] second_det_code;
    logic [EM_W-1:0] second_em_code;
    logic [DET_W-1:0] active_det;
    logic [EM_W-1:0] active_em;

    // Detector code to channel mask; reserved codes connect nothing
    function automatic logic [DET_W-1:0] det_mask(input logic [DET_W-1:0] code);
        logic [DET_W-1:0] mask;
        mask = DET_NONE_MASK;
        case (code)
            DET_PAIR_CODE: begin
                mask = DET_PAIR_MASK; // [R1] [R2]
            end
            DET_ALL_CODE: begin
                mask = DET_ALL_MASK; // [R1] [R2]
            end
            default: begin
                mask = DET_NONE_MASK;
            end
        endcase
        return mask;
    endfunction

    // Slot selection value including a write in this very cycle
    always_comb begin
        slot_sel_new = state_reg.slot_sel;
        if (reg_wr_i && (reg_addr_i == SLOT_SEL_ADDR)) begin
            slot_sel_new = reg_wdata_i; // [R5]
        end
    end

    // Field codes as a start pulse would capture them
    assign first_det_code = slot_sel_new[FIRST_DET_LSB +: DET_W];
    assign first_em_code = slot_sel_new[FIRST_EM_LSB +: EM_W];
    assign second_det_code = slot_sel_new[SEC_DET_LSB +: DET_W];
    assign second_em_code = slot_sel_new[SEC_EM_LSB +: EM_W];

    // Selection of the slot currently being measured
    always_comb begin
        active_det = DET_NONE_MASK;
        active_em = '0;
        case (state_reg.phase)
            SLOT_FIRST: begin
                active_det = state_reg.first_det;
                active_em = state_reg.first_em;
            end
            SLOT_SECOND: begin
                active_det = state_reg.second_det;
                active_em = state_reg.second_em;
            end
            default: begin
                active_det = DET_NONE_MASK;
                active_em = '0;
            end
        endcase
    end

    // Register file, slot latches and drive decode
    always_comb begin
        state_next = state_reg;
        state_next.rvalid = 1'b0;
        state_next.addr_err = 1'b0;

        // Host writes store all sixteen bits
        if (reg_wr_i) begin
            case (reg_addr_i)
                SLOT_SEL_ADDR: begin
                    state_next.slot_sel = reg_wdata_i;
                end
                CURRENT_CFG_ADDR: begin
                    state_next.current_cfg = reg_wdata_i;
                end
                default: begin
                    state_next.addr_err = 1'b1;
                end
            endcase
        end

        // Host reads answer one cycle later; unmapped reads return zero
        if (reg_rd_i) begin
            state_next.rvalid = 1'b1;
            case (reg_addr_i)
                SLOT_SEL_ADDR: begin
                    state_next.rdata = state_reg.slot_sel;
                end
                CURRENT_CFG_ADDR: begin
                    state_next.rdata = state_reg.current_cfg;
                end
                default: begin
                    state_next.rdata = '0;
                    state_next.addr_err = 1'b1;
                end
            endcase
        end

        // Capture each slot's fields at its start
        if (first_slot_start_i) begin
            state_next.first_det = det_mask(first_det_code); // [R10]
            state_next.first_em = first_em_code; // [R10]
        end
        if (second_slot_start_i) begin
            state_next.second_det = det_mask(second_det_code); // [R10]
            state_next.second_em = second_em_code; // [R10]
        end

        // Slot phase follows the timing core; first slot has priority
        if (first_slot_active_i) begin
            state_next.phase = SLOT_FIRST; // [R10]
        end else if (second_slot_active_i) begin
            state_next.phase = SLOT_SECOND; // [R10]
        end else begin
            state_next.phase = SLOT_IDLE;
        end

        // Drive only during the slot; reserved emitter codes pulse nothing
        state_next.det_connect = active_det; // [R1] [R2] [R10]
        state_next.em_one = (active_em == EM_ONE_CODE); // [R3] [R4]
        state_next.em_two = (active_em == EM_TWO_CODE); // [R3] [R4]
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
            state_reg.slot_sel <= SLOT_SEL_RESET;
            state_reg.current_cfg <= CURRENT_CFG_RESET;
            state_reg.phase <= SLOT_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Emitter one current target arithmetic
    emitter_one_current_calc u_current_calc (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .scale_bit_i(state_reg.current_cfg[SCALE_BIT]), // [R6]
        .coarse_code_i(state_reg.current_cfg[COARSE_LSB +: COARSE_W]), // [R7]
        .fine_code_i(emitter_one_fine_code_i), // [R8]
        .scale_tenths_o(emitter_one_scale_tenths_o),
        .coarse_half_ma_o(emitter_one_coarse_half_ma_o),
        .fine_milli_o(emitter_one_fine_milli_o),
        .nominal_ma_o(emitter_one_nominal_ma_o),
        .peak_target_o(emitter_one_peak_target_o)
    );

    // Outputs straight from the state register
    assign reg_rdata_o = state_reg.rdata;
    assign reg_rvalid_o = state_reg.rvalid;
    assign reg_addr_err_o = state_reg.addr_err;
    assign detector_connect_o = state_reg.det_connect;
    assign emitter_one_pulse_o = state_reg.em_one;
    assign emitter_two_pulse_o = state_reg.em_two;
    assign emitter_one_scale_o = state_reg.current_cfg[SCALE_BIT]; // [R6]
    assign emitter_one_coarse_code_o = state_reg.current_cfg[COARSE_LSB +: COARSE_W]; // [R7]

endmodule

// *** bench/led_slot_config_regs_chk.sv ***
`timescale 1ns/1ps
module led_slot_config_regs_chk
    import led_slot_cfg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [FINE_W-1:0] emitter_one_fine_code_i,
    input wire logic first_slot_active_i,
    input wire logic second_slot_active_i,
    input wire logic reg_rvalid_o,
    input wire logic reg_addr_err_o,
    input wire logic [DET_W-1:0] detector_connect_o,
    input wire logic emitter_one_pulse_o,
    input wire logic emitter_two_pulse_o,
    input wire logic emitter_one_scale_o,
    input wire logic [COARSE_W-1:0] emitter_one_coarse_code_o,
    input wire logic [SCALE_VAL_W-1:0] emitter_one_scale_tenths_o,
    input wire logic [COARSE_VAL_W-1:0] emitter_one_coarse_half_ma_o,
    input wire logic [FINE_VAL_W-1:0] emitter_one_fine_milli_o,
    input wire logic [NOMINAL_W-1:0] emitter_one_nominal_ma_o,
    input wire logic [PEAK_W-1:0] emitter_one_peak_target_o
);
    logic [1:0] up_reg;
    logic mapped;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // Settles a few edges after reset so calc pipelines are full
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            up_reg <= 2'h0;
        end else if (up_reg != 2'h3) begin
            up_reg <= up_reg + 2'h1;
        end
    end
    // Decoded register offsets
    assign mapped = reg_addr_i == SLOT_SEL_ADDR || reg_addr_i == CURRENT_CFG_ADDR;
    chk_read_valid: assert property (reg_rd_i && mapped |=> reg_rvalid_o)
        else $error("read not answered one cycle later");
    chk_unmapped_err: assert property ((reg_rd_i || reg_wr_i) && !mapped |=> reg_addr_err_o)
        else $error("unmapped access not flagged");
    chk_scale_mult: assert property (up_reg == 2'h3 |->
        emitter_one_scale_tenths_o == ($past(emitter_one_scale_o) ? 4'ha : 4'h4))
        else $error("scale multiplier wrong");
    chk_coarse_target: assert property (up_reg == 2'h3 |->
        emitter_one_coarse_half_ma_o == 10'h038 + 10'h01f * $past(emitter_one_coarse_code_o))
        else $error("coarse target wrong");
    chk_nominal_list: assert property (up_reg == 2'h3 |->
        emitter_one_nominal_ma_o == 8'h19 + 8'h0f * $past(emitter_one_coarse_code_o))
        else $error("nominal current wrong");
    chk_fine_mult: assert property (up_reg == 2'h3 |->
        emitter_one_fine_milli_o == 11'h2c6 + 11'h018 * $past(emitter_one_fine_code_i))
        else $error("fine multiplier wrong");
    chk_peak_product: assert property (up_reg == 2'h3 |->
        emitter_one_peak_target_o == $past(emitter_one_coarse_half_ma_o)
        * $past(emitter_one_fine_milli_o) * $past(emitter_one_scale_tenths_o))
        else $error("peak product wrong");
    chk_slot_idle: assert property (up_reg == 2'h3 && !$past(first_slot_active_i, 2)
        && !$past(second_slot_active_i, 2) |-> detector_connect_o == 4'h0
        && !emitter_one_pulse_o && !emitter_two_pulse_o)
        else $error("drive outside a slot");
    chk_one_emitter: assert property (!(emitter_one_pulse_o && emitter_two_pulse_o))
        else $error("both emitters driven");
    chk_det_codes: assert property (detector_connect_o inside {4'h0, 4'hc, 4'hf})
        else $error("illegal detector mask");
    cover property (reg_addr_err_o);
    cover property (emitter_two_pulse_o);
    cover property (detector_connect_o == 4'hc);
    cover property (first_slot_active_i && second_slot_active_i);
endmodule
bind led_slot_config_regs led_slot_config_regs_chk led_slot_config_regs_chk_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .emitter_one_fine_code_i(emitter_one_fine_code_i),
    .first_slot_active_i(first_slot_active_i), .second_slot_active_i(second_slot_active_i),
    .reg_rvalid_o(reg_rvalid_o), .reg_addr_err_o(reg_addr_err_o),
    .detector_connect_o(detector_connect_o), .emitter_one_pulse_o(emitter_one_pulse_o),
    .emitter_two_pulse_o(emitter_two_pulse_o), .emitter_one_scale_o(emitter_one_scale_o),
    .emitter_one_coarse_code_o(emitter_one_coarse_code_o),
    .emitter_one_scale_tenths_o(emitter_one_scale_tenths_o),
    .emitter_one_coarse_half_ma_o(emitter_one_coarse_half_ma_o),
    .emitter_one_fine_milli_o(emitter_one_fine_milli_o),
    .emitter_one_nominal_ma_o(emitter_one_nominal_ma_o),
    .emitter_one_peak_target_o(emitter_one_peak_target_o));

// *** bench/test_led_slot_config_regs.sv ***
`timescale 1ns/1ps
module test_led_slot_config_regs;
    import led_slot_cfg_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic wr = 1'b0, rd = 1'b0, rvalid, aerr, e1, e2, sc;
    logic [4:0] fine = 5'h00;
    logic [1:0] st = 2'h0, ac = 2'h0;
    logic [3:0] det, cc, tn;
    logic [9:0] hm;
    logic [10:0] fm;
    logic [7:0] nm;
    logic [24:0] pk;
    logic [3:0] dtab [4] = '{4'h1, 4'h4, 4'h7, 4'h0};
    int num_errors = 0, comparisons = 0, cyc = 0;
    led_slot_config_regs led_slot_config_regs_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .emitter_one_fine_code_i(fine), .first_slot_start_i(st[0]),
        .second_slot_start_i(st[1]), .first_slot_active_i(ac[0]),
        .second_slot_active_i(ac[1]), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .reg_addr_err_o(aerr), .detector_connect_o(det), .emitter_one_pulse_o(e1),
        .emitter_two_pulse_o(e2), .emitter_one_scale_o(sc), .emitter_one_coarse_code_o(cc),
        .emitter_one_scale_tenths_o(tn), .emitter_one_coarse_half_ma_o(hm),
        .emitter_one_fine_milli_o(fm), .emitter_one_nominal_ma_o(nm),
        .emitter_one_peak_target_o(pk));
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    task wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            wrap_up();
        end
    end
    task chk(input string n, input logic [24:0] got, input logic [24:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, exp, got);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk_sys_i);
        #1 wr = 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask
    task rd_reg(input logic [7:0] a, input logic [15:0] exp, input logic err);
        addr = a;
        rd = 1'b1;
        @(posedge clk_sys_i);
        #1 rd = 1'b0;
        chk("rvalid", rvalid, 1'b1);
        chk("rdata", rdata, exp);
        chk("addr_err", aerr, err);
        @(posedge clk_sys_i);
        #1;
    endtask
    // Runs one slot; a rewrite mid-slot must not disturb the latched drive
    task slot(input int s, input logic [3:0] code, input logic [1:0] em);
        st[s] = 1'b1;
        ac[s] = 1'b1;
        @(posedge clk_sys_i);
        #1 st[s] = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        for (int k = 0; k < 2; k++) begin
            chk("det", det, code == 4'h1 ? 4'hc : code == 4'h4 ? 4'hf : 4'h0);
            chk("em_one", e1, em == 2'h1);
            chk("em_two", e2, em == 2'h2);
            if (k == 0) wr_reg(SLOT_SEL_ADDR, 16'h0000);
        end
        ac[s] = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk("idle", {det, e1, e2}, 6'h00);
    endtask
    initial begin
        logic [15:0] v;
        repeat (10) @(posedge clk_sys_i);
        #1 sys_rst_i = 1'b0;
        rd_reg(SLOT_SEL_ADDR, 16'h0541, 1'b0);
        rd_reg(CURRENT_CFG_ADDR, 16'h3000, 1'b0);
        rd_reg(8'h15, 16'h0000, 1'b1);
        $display("test reset done");
        for (int c = 0; c < 16; c++) begin
            fine = 5'(2 * c + 1);
            v = {2'h0, c[0], 1'b1, 8'h03, c[3:0]};
            wr_reg(CURRENT_CFG_ADDR, v);
            repeat (2) @(posedge clk_sys_i);
            #1;
            chk("coarse_code", cc, c[3:0]);
            chk("scale", sc, c[0]);
            chk("tenths", tn, c[0] ? 4'ha : 4'h4);
            chk("half_ma", hm, 10'h038 + 10'h01f * c);
            chk("nominal", nm, 8'h19 + 8'h0f * c);
            chk("fine", fm, 11'h2c6 + 11'h018 * fine);
            chk("peak", pk, (56 + 31 * c) * (710 + 24 * (2 * c + 1)) * (c[0] ? 10 : 4));
            rd_reg(CURRENT_CFG_ADDR, v, 1'b0);
        end
        wr_reg(8'h22, 16'hffff);
        rd_reg(CURRENT_CFG_ADDR, v, 1'b0);
        $display("test current done");
        for (int i = 0; i < 4; i++) begin
            v = {4'h0, dtab[3-i], dtab[i], 2'(3 - i), 2'(i)};
            wr_reg(SLOT_SEL_ADDR, v);
            slot(0, dtab[i], 2'(i));
            wr_reg(SLOT_SEL_ADDR, v);
            slot(1, dtab[3-i], 2'(3 - i));
        end
        $display("test slots done");
        // Start pulses with a write in the same cycle; both active, first wins
        addr = SLOT_SEL_ADDR;
        wdata = 16'h0416;
        wr = 1'b1;
        st = 2'h3;
        ac = 2'h3;
        @(posedge clk_sys_i);
        #1 wr = 1'b0;
        st = 2'h0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("det_both", det, 4'hc);
        chk("em_both", {e1, e2}, 2'h1);
        ac = 2'h2;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("det_second", det, 4'hf);
        chk("em_second", {e1, e2}, 2'h2);
        ac = 2'h0;
        $display("test overlap done");
        // Second reset mid-run brings registers and drive back to defaults
        repeat (3) @(posedge clk_sys_i);
        #1 sys_rst_i = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1 sys_rst_i = 1'b0;
        chk("rst_drive", {det, e1, e2, sc, cc}, 11'h010);
        chk("rst_peak", pk, 25'h0);
        rd_reg(SLOT_SEL_ADDR, 16'h0541, 1'b0);
        rd_reg(CURRENT_CFG_ADDR, 16'h3000, 1'b0);
        $display("test reset again done");
        wrap_up();
    end
endmodule
